// ==== rtl/fpec_pkg.sv ====
// shared constants and types for the flash program/erase controller
package fpec_pkg;

  // register byte offsets on the AXI4-Lite port
  localparam logic [7:0] OFS_MODE         = 8'h00; // flash_mode_control
  localparam logic [7:0] OFS_CLK_NOTIFY   = 8'h04; // flash_clock_notify
  localparam logic [7:0] OFS_STARTUP_STAT = 8'h08; // startup_window_status
  localparam logic [7:0] OFS_CMD          = 8'h0C;
  localparam logic [7:0] OFS_ADDR         = 8'h10;
  localparam logic [7:0] OFS_WDATA        = 8'h14;
  localparam logic [7:0] OFS_STATUS       = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT     = 8'h1C;
  localparam logic [7:0] OFS_IRQ_CLR      = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN       = 8'h24;
  localparam logic [7:0] OFS_ID_KEY       = 8'h28;
  localparam logic [7:0] OFS_WIN_START    = 8'h2C;
  localparam logic [7:0] OFS_WIN_END      = 8'h30;

  // flash mode field encodings
  localparam logic [1:0] MODE_READ    = 2'h0;
  localparam logic [1:0] MODE_CODE_PE = 2'h1;
  localparam logic [1:0] MODE_DATA_PE = 2'h2;
  localparam logic [1:0] MODE_BAD     = 2'h3;
  localparam int         MODE_GUARD_BIT = 4;   // start-up guard enable in mode register
  localparam logic [7:0] RST_MODE       = 8'h00;
  localparam logic [7:0] RST_CLK_NOTIFY = 8'h00;

  // command opcodes
  localparam logic [3:0] CMD_PROGRAM     = 4'h1;
  localparam logic [3:0] CMD_BLANK       = 4'h2;
  localparam logic [3:0] CMD_ERASE_BLK   = 4'h3;
  localparam logic [3:0] CMD_ERASE_ALL   = 4'h4;
  localparam logic [3:0] CMD_STARTUP_PGM = 4'h5;
  localparam logic [3:0] CMD_WIN_PROTECT = 4'h6;
  localparam logic [3:0] CMD_WIN_PGM     = 4'h7;
  localparam logic [3:0] CMD_FORCE_STOP  = 4'hF;

  // operation times in microseconds
  localparam logic [15:0] PROGRAM_US   = 16'h0008;
  localparam logic [15:0] BLANK_US     = 16'h0002;
  localparam logic [15:0] ERASE_BLK_US = 16'h0010;
  localparam logic [15:0] ERASE_ALL_US = 16'h0040;
  localparam logic [15:0] EXTRA_US     = 16'h0008;

  // user area layout
  localparam int          ADDR_W      = 19;
  localparam int          BLOCK_SHIFT = 13;
  localparam logic [18:0] ID_SLOT     = 19'h00001; // start-up program target for the id word

  // extra area reset values (erased state)
  localparam logic [31:0] RST_XA_WORD = 32'hFFFFFFFF;

  // status and interrupt bit positions
  localparam int STAT_BUSY   = 0;
  localparam int STAT_ERR    = 1;
  localparam int STAT_BLANK  = 2;
  localparam int STAT_UNLOCK = 3;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_ERR     = 1;
  localparam int SUS_PROTECT = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // request held toward the flash array while an operation runs
  typedef struct packed {
    logic              act;
    logic [3:0]        op;
    logic              dataArea;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
  } fpec_arr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } fpec_state_t;

endpackage

// ==== rtl/fpec_timer.sv ====
// microsecond operation timer paced by the notified clock frequency
module fpec_timer (
  input  wire logic        ref_clk,  // flash interface clock
  input  wire logic        rst_b,    // async reset, active low
  input  wire logic        start,    // load and run
  input  wire logic        abort,    // stop without done
  input  wire logic [5:0]  freqMhz,  // notified clock in MHz
  input  wire logic [15:0] timeUs,   // duration in microseconds
  output logic             done      // one-cycle end pulse
);

  logic [5:0]  pre_q;
  logic [15:0] usLeft_q;
  logic        run_q;
  logic [5:0]  preLim;

  // zero notification treated as 1 MHz so the timer always ends
  assign preLim = (freqMhz == 6'h00) ? 6'h00 : freqMhz - 6'h01;

  // prescaler gives one tick per microsecond at the notified rate
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q    <= 6'h00;
      usLeft_q <= 16'h0000;
      run_q    <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        pre_q    <= 6'h00;
        usLeft_q <= timeUs;
        run_q    <= 1'b1;
      end else if (abort) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        if (pre_q >= preLim) begin
          pre_q <= 6'h00;
          if (usLeft_q <= 16'h0001) begin
            run_q <= 1'b0;
            done  <= 1'b1;
          end else begin
            usLeft_q <= usLeft_q - 16'h0001;
          end
        end else begin
          pre_q <= pre_q + 6'h01;
        end
      end
    end
  end

endmodule

// ==== rtl/fpec_ctrl.sv ====
// flash program/erase controller with AXI4-Lite register port
// What this block does
// - mode 00 read, 01 code, 10 data
// - ready interrupt on command or stop completion
// - program, blank check, block and all erase
// - start-up info, window protect, window info
// - code flash programming only inside permitted window
// - code flash readable while data flash programs
// - guard active start-up half, blocks 0-3 or 4-7
// - clock field sets program/erase timing
// - readable window protection flag
// - id code gates programmer and debugger connection
module fpec_ctrl (
  input  wire logic              ref_clk,        // flash interface clock
  input  wire logic              rst_b,          // async reset, active low
  input  wire logic [7:0]        s_axi_awaddr,   // write address
  input  wire logic              s_axi_awvalid,  // write address valid
  output logic                   s_axi_awready,  // write address ready
  input  wire logic [31:0]       s_axi_wdata,    // write data
  input  wire logic [3:0]        s_axi_wstrb,    // write byte enables
  input  wire logic              s_axi_wvalid,   // write data valid
  output logic                   s_axi_wready,   // write data ready
  output logic [1:0]             s_axi_bresp,    // write response
  output logic                   s_axi_bvalid,   // write response valid
  input  wire logic              s_axi_bready,   // write response ready
  input  wire logic [7:0]        s_axi_araddr,   // read address
  input  wire logic              s_axi_arvalid,  // read address valid
  output logic                   s_axi_arready,  // read address ready
  output logic [31:0]            s_axi_rdata,    // read data
  output logic [1:0]             s_axi_rresp,    // read response
  output logic                   s_axi_rvalid,   // read data valid
  input  wire logic              s_axi_rready,   // read data ready
  input  wire logic              arrayBlank,     // array reports blank
  input  wire logic              bootMode,       // device in boot mode
  output fpec_pkg::fpec_arr_t    arrayReq,       // request to flash array
  output logic                   codeReadEn,     // code flash readable
  output logic                   dataReadEn,     // data flash readable
  output logic                   serialConnOk,   // serial programmer allowed
  output logic                   debugConnOk,    // debugger allowed
  output logic                   irq             // flash_done_interrupt
);

  // bus state
  logic        awHeld_q, wHeld_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        wrDo;
  logic [31:0] rdMux;

  localparam int ADDR_W_L = fpec_pkg::ADDR_W;

  // registers
  logic [7:0]  mode_q, clkNotify_q;
  logic [ADDR_W_L-1:0] addr_q;
  logic [31:0] wdataReg_q;
  logic [1:0]  irqStat_q, irqEn_q;
  logic        lastErr_q, blank_q, unlock_q;
  logic [31:0] xaStartup_q, xaWinStart_q, xaWinEnd_q, xaProtect_q, xaId_q;

  // sequencer
  fpec_pkg::fpec_state_t state_q;
  logic [3:0]  cmd_q;
  logic        errPend_q, ranOk_q;
  logic        cmdWr, forceWr, reject, tStart, tAbort, tDone;
  logic [15:0] tUs;
  logic [3:0]  newOp;

  // merge a write with byte enables
  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // true for offsets that hold a register
  function automatic logic isMapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= fpec_pkg::OFS_WIN_END);
  endfunction

  // operation duration in microseconds
  function automatic logic [15:0] opTime(input logic [3:0] op);
    case (op)
      fpec_pkg::CMD_PROGRAM:   opTime = fpec_pkg::PROGRAM_US;
      fpec_pkg::CMD_BLANK:     opTime = fpec_pkg::BLANK_US;
      fpec_pkg::CMD_ERASE_BLK: opTime = fpec_pkg::ERASE_BLK_US;
      fpec_pkg::CMD_ERASE_ALL: opTime = fpec_pkg::ERASE_ALL_US;
      default:                 opTime = fpec_pkg::EXTRA_US;
    endcase
  endfunction

  // write address and data taken in either order, response after both
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      awAddr_q      <= 8'h00;
      wData_q       <= 32'h00000000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= fpec_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !wHeld_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrDo) begin
        awHeld_q      <= 1'b0;
        wHeld_q       <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= isMapped(awAddr_q) ? fpec_pkg::RESP_OKAY : fpec_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wrDo    = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign cmdWr   = wrDo && (awAddr_q == fpec_pkg::OFS_CMD) && wStrb_q[0];
  assign newOp   = wData_q[3:0];
  assign forceWr = cmdWr && (newOp == fpec_pkg::CMD_FORCE_STOP);

  // read port answers one cycle after the address is taken
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= fpec_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdMux;
        s_axi_rresp   <= isMapped(s_axi_araddr) ? fpec_pkg::RESP_OKAY : fpec_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // read data mux; reserved bits and write-only registers read zero
  always_comb begin
    rdMux = 32'h00000000;
    case (s_axi_araddr)
      fpec_pkg::OFS_MODE:       rdMux[7:0] = mode_q;
      fpec_pkg::OFS_CLK_NOTIFY: rdMux[5:0] = clkNotify_q[5:0];
      fpec_pkg::OFS_STARTUP_STAT: begin
        rdMux[0]                     = xaStartup_q[0];
        rdMux[fpec_pkg::SUS_PROTECT] = !xaProtect_q[0];
      end
      fpec_pkg::OFS_ADDR:  rdMux[ADDR_W_L-1:0] = addr_q;
      fpec_pkg::OFS_WDATA: rdMux = wdataReg_q;
      fpec_pkg::OFS_STATUS: begin
        rdMux[fpec_pkg::STAT_BUSY]   = (state_q != fpec_pkg::ST_IDLE);
        rdMux[fpec_pkg::STAT_ERR]    = lastErr_q;
        rdMux[fpec_pkg::STAT_BLANK]  = blank_q;
        rdMux[fpec_pkg::STAT_UNLOCK] = unlock_q || (&xaId_q);
      end
      fpec_pkg::OFS_IRQ_STAT:  rdMux[1:0] = irqStat_q;
      fpec_pkg::OFS_IRQ_EN:    rdMux[1:0] = irqEn_q;
      fpec_pkg::OFS_WIN_START: rdMux[ADDR_W_L-1:0] = xaWinStart_q[ADDR_W_L-1:0];
      fpec_pkg::OFS_WIN_END:   rdMux[ADDR_W_L-1:0] = xaWinEnd_q[ADDR_W_L-1:0];
      default:                 rdMux = 32'h00000000;
    endcase
  end

  // software registers; mode, clock and operands frozen while busy
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q      <= fpec_pkg::RST_MODE;
      clkNotify_q <= fpec_pkg::RST_CLK_NOTIFY;
      addr_q      <= '0;
      wdataReg_q  <= 32'h00000000;
      irqEn_q     <= 2'h0;
    end else if (wrDo) begin
      case (awAddr_q)
        fpec_pkg::OFS_MODE: begin
          // prohibited encoding 11 is dropped, the old mode stays
          if (wStrb_q[0] && state_q == fpec_pkg::ST_IDLE && wData_q[1:0] != fpec_pkg::MODE_BAD) begin
            mode_q <= {3'h0, wData_q[4], 2'h0, wData_q[1:0]};
          end
        end
        fpec_pkg::OFS_CLK_NOTIFY: begin
          if (wStrb_q[0] && state_q == fpec_pkg::ST_IDLE) begin
            clkNotify_q <= {2'h0, wData_q[5:0]};
          end
        end
        fpec_pkg::OFS_ADDR: begin
          if (state_q == fpec_pkg::ST_IDLE) begin
            addr_q <= ADDR_W_L'(applyStrb({13'h0000, addr_q}, wData_q, wStrb_q));
          end
        end
        fpec_pkg::OFS_WDATA: begin
          if (state_q == fpec_pkg::ST_IDLE) begin
            wdataReg_q <= applyStrb(wdataReg_q, wData_q, wStrb_q);
          end
        end
        fpec_pkg::OFS_IRQ_EN: begin
          if (wStrb_q[0]) begin
            irqEn_q <= wData_q[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // legality check of a new command against mode, window and start-up guard
  always_comb begin
    logic [5:0] blk;
    logic       inWin, guardHit, codeMode, dataMode;
    blk      = addr_q[ADDR_W_L-1:fpec_pkg::BLOCK_SHIFT];
    codeMode = (mode_q[1:0] == fpec_pkg::MODE_CODE_PE);
    dataMode = (mode_q[1:0] == fpec_pkg::MODE_DATA_PE);
    inWin    = (addr_q >= xaWinStart_q[ADDR_W_L-1:0]) && (addr_q <= xaWinEnd_q[ADDR_W_L-1:0]);
    // active start-up half: blocks 0-3 when select bit is 1, else 4-7
    guardHit = mode_q[fpec_pkg::MODE_GUARD_BIT] && (blk[5:3] == 3'h0) &&
               (blk[2] == !xaStartup_q[0]);
    reject   = 1'b0;
    case (newOp)
      fpec_pkg::CMD_PROGRAM, fpec_pkg::CMD_ERASE_BLK: begin
        reject = !(codeMode || dataMode) ||
                 (codeMode && (!inWin || guardHit));
      end
      fpec_pkg::CMD_BLANK: begin
        reject = !(codeMode || dataMode);
      end
      fpec_pkg::CMD_ERASE_ALL: begin
        reject = !(codeMode || dataMode) ||
                 (codeMode && (mode_q[fpec_pkg::MODE_GUARD_BIT] || xaWinStart_q[ADDR_W_L-1:0] != '0 ||
                               xaWinEnd_q[ADDR_W_L-1:0] != '1));
      end
      fpec_pkg::CMD_STARTUP_PGM: begin
        reject = !codeMode;
      end
      fpec_pkg::CMD_WIN_PROTECT, fpec_pkg::CMD_WIN_PGM: begin
        reject = !codeMode || !xaProtect_q[0];
      end
      default: begin
        reject = 1'b1;
      end
    endcase
  end

  // sequencer: accept in idle only, force stop ends a run early
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= fpec_pkg::ST_IDLE;
      cmd_q     <= 4'h0;
      errPend_q <= 1'b0;
      ranOk_q   <= 1'b0;
    end else begin
      case (state_q)
        fpec_pkg::ST_IDLE: begin
          if (forceWr) begin
            state_q   <= fpec_pkg::ST_DONE;
            errPend_q <= 1'b0;
            ranOk_q   <= 1'b0;
          end else if (cmdWr) begin
            cmd_q     <= newOp;
            errPend_q <= reject;
            ranOk_q   <= 1'b0;
            state_q   <= reject ? fpec_pkg::ST_DONE : fpec_pkg::ST_RUN;
          end
        end
        fpec_pkg::ST_RUN: begin
          // other commands while running are dropped on purpose
          if (forceWr) begin
            state_q <= fpec_pkg::ST_DONE;
          end else if (tDone) begin
            ranOk_q <= 1'b1;
            state_q <= fpec_pkg::ST_DONE;
          end
        end
        fpec_pkg::ST_DONE: begin
          state_q <= fpec_pkg::ST_IDLE;
        end
        default: begin
          state_q <= fpec_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign tStart = (state_q == fpec_pkg::ST_IDLE) && cmdWr && !forceWr && !reject;
  assign tAbort = (state_q == fpec_pkg::ST_RUN) && forceWr;
  assign tUs    = opTime(newOp);

  fpec_timer u_timer (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .start   (tStart),
    .abort   (tAbort),
    .freqMhz (clkNotify_q[5:0]),
    .timeUs  (tUs),
    .done    (tDone)
  );

  // completion results: error flag and blank check outcome
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lastErr_q <= 1'b0;
      blank_q   <= 1'b0;
    end else if (state_q == fpec_pkg::ST_DONE) begin
      lastErr_q <= errPend_q;
    end else if (state_q == fpec_pkg::ST_RUN && tDone && cmd_q == fpec_pkg::CMD_BLANK) begin
      blank_q <= arrayBlank;
    end
  end

  // extra area contents, updated only when an extra command finishes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      xaStartup_q  <= fpec_pkg::RST_XA_WORD;
      xaWinStart_q <= 32'h00000000;
      xaWinEnd_q   <= fpec_pkg::RST_XA_WORD;
      xaProtect_q  <= fpec_pkg::RST_XA_WORD;
      xaId_q       <= fpec_pkg::RST_XA_WORD;
    end else if (state_q == fpec_pkg::ST_DONE && ranOk_q) begin
      case (cmd_q)
        fpec_pkg::CMD_STARTUP_PGM: begin
          if (addr_q == fpec_pkg::ID_SLOT) begin
            xaId_q <= wdataReg_q;
          end else begin
            xaStartup_q <= wdataReg_q;
          end
        end
        fpec_pkg::CMD_WIN_PROTECT: begin
          xaProtect_q <= 32'h00000000;
        end
        fpec_pkg::CMD_WIN_PGM: begin
          xaWinStart_q <= {13'h0000, addr_q};
          xaWinEnd_q   <= {13'h0000, wdataReg_q[ADDR_W_L-1:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStat_q <= 2'h0;
      irq       <= 1'b0;
    end else begin
      logic [1:0] clr, set;
      clr = (wrDo && awAddr_q == fpec_pkg::OFS_IRQ_CLR && wStrb_q[0]) ? wData_q[1:0] : 2'h0;
      set = 2'h0;
      set[fpec_pkg::IRQ_DONE] = (state_q == fpec_pkg::ST_DONE);
      set[fpec_pkg::IRQ_ERR]  = (state_q == fpec_pkg::ST_DONE) && errPend_q;
      irqStat_q <= (irqStat_q & ~clr) | set;
      irq       <= |(irqStat_q & irqEn_q);
    end
  end

  // id key check gates serial programmer and debugger connection
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      unlock_q     <= 1'b0;
      serialConnOk <= 1'b0;
      debugConnOk  <= 1'b0;
    end else begin
      if (wrDo && awAddr_q == fpec_pkg::OFS_ID_KEY && wStrb_q == 4'hF) begin
        unlock_q <= (applyStrb(32'h00000000, wData_q, wStrb_q) == xaId_q);
      end
      // erased id word means no code was set, connection is free
      serialConnOk <= bootMode && (unlock_q || (&xaId_q));
      debugConnOk  <= unlock_q || (&xaId_q);
    end
  end

  // read enables and array request follow mode and sequencer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      codeReadEn <= 1'b1;
      dataReadEn <= 1'b1;
      arrayReq   <= '0;
    end else begin
      // code flash stays readable in data P/E so fetch goes on
      codeReadEn <= (mode_q[1:0] != fpec_pkg::MODE_CODE_PE);
      dataReadEn <= (mode_q[1:0] == fpec_pkg::MODE_READ);
      if (tStart) begin
        arrayReq.act      <= 1'b1;
        arrayReq.op       <= newOp;
        arrayReq.dataArea <= (mode_q[1:0] == fpec_pkg::MODE_DATA_PE);
        arrayReq.addr     <= addr_q;
        arrayReq.data     <= wdataReg_q;
      end else if (state_q != fpec_pkg::ST_RUN || tDone || tAbort) begin
        arrayReq.act <= 1'b0;
      end
    end
  end

endmodule

// ==== verif/fpec_ctrl_assertions.sv ====
// port checks for the flash program/erase controller
module fpec_ctrl_assertions (
  input wire logic                ref_clk,       // clock
  input wire logic                rst_b,         // reset, active low
  input wire logic                bootMode,      // boot strap
  input wire fpec_pkg::fpec_arr_t arrayReq,      // array request
  input wire logic                codeReadEn,    // code readable
  input wire logic                dataReadEn,    // data readable
  input wire logic                serialConnOk,  // programmer gate
  input wire logic                debugConnOk,   // debugger gate
  input wire logic                irq,           // done interrupt
  input wire logic                s_axi_arvalid, // read addr valid
  input wire logic                s_axi_arready, // read addr ready
  input wire logic                s_axi_rvalid   // read data valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // data array work must never stall instruction fetch
  a_bgo_code_read: assert property (arrayReq.act && arrayReq.dataArea |-> codeReadEn)
    else $error("code closed in data op");
  a_run_no_read: assert property (arrayReq.act |-> !dataReadEn)
    else $error("data read open in run");
  a_busy_op_hold: assert property (arrayReq.act && $past(arrayReq.act) |-> $stable(arrayReq.op))
    else $error("op changed in run");
  a_op_known: assert property (arrayReq.act |-> arrayReq.op inside {[fpec_pkg::CMD_PROGRAM:fpec_pkg::CMD_WIN_PGM]})
    else $error("bad op to array");
  a_done_irq: assert property ($fell(arrayReq.act) |-> ##[1:4] irq)
    else $error("no done irq");
  a_serial_boot: assert property (serialConnOk |-> $past(bootMode))
    else $error("serial outside boot");
  a_serial_debug: assert property (serialConnOk |-> debugConnOk)
    else $error("serial without debug");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule

bind fpec_ctrl fpec_ctrl_assertions u_chk (.*);

// ==== verif/fpec_array_model.sv ====
// behavioural flash array answering blank checks
module fpec_array_model (
  input  wire logic                ref_clk,    // clock
  input  wire logic                rst_b,      // reset, active low
  input  wire fpec_pkg::fpec_arr_t arrayReq,   // request from controller
  output logic                     arrayBlank  // blank answer
);
  logic blank_q, wobble_q;
  // erase blanks, program dirties; answer wobbles outside a blank check
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      blank_q  <= 1'b0;
      wobble_q <= 1'b0;
    end else begin
      wobble_q <= ~wobble_q;
      if (arrayReq.act && arrayReq.op == fpec_pkg::CMD_PROGRAM)
        blank_q <= 1'b0;
      else if (arrayReq.act && arrayReq.op inside {fpec_pkg::CMD_ERASE_BLK, fpec_pkg::CMD_ERASE_ALL})
        blank_q <= 1'b1;
    end
  end
  assign arrayBlank = (arrayReq.act && arrayReq.op == fpec_pkg::CMD_BLANK) ? blank_q : wobble_q;
endmodule

// ==== verif/tb_top.sv ====
// register-level bench for the flash program/erase controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk, rst_b, bootMode, arrayBlank, codeReadEn, dataReadEn, serialConnOk, debugConnOk, irq;
  logic [7:0]          s_axi_awaddr, s_axi_araddr;
  logic [31:0]         s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]          s_axi_wstrb;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  fpec_pkg::fpec_arr_t arrayReq;
  int                  nMismatch, checkCount, cyc;

  fpec_ctrl dut (.*);
  fpec_array_model u_arr (.*);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // offer both channels, drop each once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er = fpec_pkg::RESP_OKAY);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  // command, timed wait for irq, status check and clear
  task automatic run(input logic [3:0] op, input logic [31:0] st, input int us);
    int n;
    n = 0;
    wr(fpec_pkg::OFS_CMD, {28'h0, op});
    while (irq !== 1'b1) begin
      @(posedge ref_clk);
      n++;
    end
    chk("duration", 32'h1, {31'h0, n <= us + 8 && n + 2 >= us});
    rd(fpec_pkg::OFS_IRQ_STAT);
    chk("irq status", st, rdv);
    wr(fpec_pkg::OFS_IRQ_CLR, 32'h3);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang ceiling, far above the longest run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      nMismatch++;
      summarize;
    end
  end

  initial begin
    {rst_b, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    bootMode = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(fpec_pkg::OFS_MODE);
    chk("mode reset", {24'h0, fpec_pkg::RST_MODE}, rdv);
    rd(fpec_pkg::OFS_STARTUP_STAT);
    chk("protect flag", 32'h0, rdv & 32'h100);
    rd(8'h34, fpec_pkg::RESP_SLVERR);
    chk("serial open", 32'h1, {31'h0, serialConnOk});
    wr(fpec_pkg::OFS_IRQ_EN, 32'h3);
    wr(fpec_pkg::OFS_CLK_NOTIFY, 32'h1);
    wr(fpec_pkg::OFS_MODE, 32'h3);
    rd(fpec_pkg::OFS_MODE);
    chk("mode 11 dropped", 32'h0, rdv);
    run(fpec_pkg::CMD_PROGRAM, 32'h3, 0);
    wr(fpec_pkg::OFS_MODE, {30'h0, fpec_pkg::MODE_DATA_PE});
    run(fpec_pkg::CMD_PROGRAM, 32'h1, 8);
    run(fpec_pkg::CMD_BLANK, 32'h1, 2);
    rd(fpec_pkg::OFS_STATUS);
    chk("not blank", 32'h0, rdv & 32'h4);
    run(fpec_pkg::CMD_ERASE_BLK, 32'h1, 16);
    run(fpec_pkg::CMD_BLANK, 32'h1, 2);
    rd(fpec_pkg::OFS_STATUS);
    chk("blank", 32'h4, rdv & 32'h4);
    wr(fpec_pkg::OFS_CLK_NOTIFY, 32'h2);
    run(fpec_pkg::CMD_PROGRAM, 32'h1, 16);
    run(fpec_pkg::CMD_STARTUP_PGM, 32'h3, 0);
    // busy drops a command; stop cuts the erase
    wr(fpec_pkg::OFS_CMD, {28'h0, fpec_pkg::CMD_ERASE_ALL});
    wr(fpec_pkg::OFS_CMD, {28'h0, fpec_pkg::CMD_BLANK});
    run(fpec_pkg::CMD_FORCE_STOP, 32'h1, 0);
    // masked event stays sticky
    wr(fpec_pkg::OFS_IRQ_EN, 32'h0);
    wr(fpec_pkg::OFS_CMD, {28'h0, fpec_pkg::CMD_STARTUP_PGM});
    repeat (4) @(posedge ref_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(fpec_pkg::OFS_IRQ_EN, 32'h3);
    run(fpec_pkg::CMD_FORCE_STOP, 32'h3, 0);
    wr(fpec_pkg::OFS_MODE, 32'h11);
    #1 chk("code read off", 32'h0, {31'h0, codeReadEn});
    wr(fpec_pkg::OFS_ADDR, 32'h4000);
    run(fpec_pkg::CMD_ERASE_BLK, 32'h3, 0);
    wr(fpec_pkg::OFS_ADDR, 32'hA000);
    run(fpec_pkg::CMD_ERASE_BLK, 32'h1, 32);
    run(fpec_pkg::CMD_ERASE_ALL, 32'h3, 0);
    wr(fpec_pkg::OFS_MODE, 32'h1);
    wr(fpec_pkg::OFS_ADDR, 32'h1);
    wr(fpec_pkg::OFS_WDATA, 32'h5A5AC3C3);
    run(fpec_pkg::CMD_STARTUP_PGM, 32'h1, 16);
    chk("conn locked", 32'h0, {30'h0, serialConnOk, debugConnOk});
    wr(fpec_pkg::OFS_ID_KEY, 32'h5A5AC3C3);
    #1 chk("conn unlocked", 32'h3, {30'h0, serialConnOk, debugConnOk});
    bootMode <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("serial boot only", 32'h1, {30'h0, serialConnOk, debugConnOk});
    wr(fpec_pkg::OFS_ADDR, 32'h10000);
    wr(fpec_pkg::OFS_WDATA, 32'h1FFFF);
    run(fpec_pkg::CMD_WIN_PGM, 32'h1, 16);
    rd(fpec_pkg::OFS_WIN_START);
    chk("window start", 32'h10000, rdv);
    run(fpec_pkg::CMD_PROGRAM, 32'h1, 16);
    wr(fpec_pkg::OFS_ADDR, 32'hFFFC);
    run(fpec_pkg::CMD_PROGRAM, 32'h3, 0);
    run(fpec_pkg::CMD_WIN_PROTECT, 32'h1, 16);
    rd(fpec_pkg::OFS_STARTUP_STAT);
    chk("protect flag", 32'h100, rdv & 32'h100);
    run(fpec_pkg::CMD_WIN_PROTECT, 32'h3, 0);
    summarize;
  end
endmodule
